// ---- rtl/asc_pkg.sv ----
package asc_pkg;

  // Widths of the converter result, channel address and input data register
  localparam int RES_W  = 12;
  localparam int ADDR_W = 4;
  localparam int DIN_W  = 8;
  localparam int N_EXT  = 11;
  localparam int CNT_W  = 5;
  localparam int CONV_W = 9;

  // Serial clock edge counts that mark the phases of a transfer
  localparam logic [CNT_W-1:0] ADDR_RISES  = 5'h04;
  localparam logic [CNT_W-1:0] DIN_RISES   = 5'h08;
  localparam logic [CNT_W-1:0] SAMPLE_FALL = 5'h04;

  // Transfer length select codes and the clock counts they give
  localparam logic [1:0]       LEN_SEL_8  = 2'h1;
  localparam logic [1:0]       LEN_SEL_16 = 2'h3;
  localparam logic [CNT_W-1:0] LEN_8      = 5'h08;
  localparam logic [CNT_W-1:0] LEN_12     = 5'h0C;
  localparam logic [CNT_W-1:0] LEN_16     = 5'h10;

  // Self-test selections and the codes they convert to
  localparam logic [ADDR_W-1:0] SEL_TEST_MID = 4'hB;
  localparam logic [ADDR_W-1:0] SEL_TEST_LO  = 4'hC;
  localparam logic [ADDR_W-1:0] SEL_TEST_HI  = 4'hD;
  localparam logic [RES_W-1:0]  TEST_MID     = 12'h800;
  localparam logic [RES_W-1:0]  TEST_LO      = 12'h000;
  localparam logic [RES_W-1:0]  TEST_HI      = 12'hFFF;
  localparam logic [RES_W-1:0]  CODE_NONE    = 12'h000;

  // Conversion time; a longest time rounds down to whole cycles
  localparam int CONV_TIME_NS  = 10000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_CYC      = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1
                                 : CONV_TIME_NS / CLK_PERIOD_NS;
  localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYC - 1);

  // Reset value of the pin synchroniser, order {data_in, io_clk, cs_n}
  localparam logic [2:0] SYNC_RST = 3'h1;

  typedef enum logic [2:0] {
    LK_IDLE  = 3'b001,
    LK_SHIFT = 3'b010,
    LK_DONE  = 3'b100
  } asc_link_e;

  typedef struct packed {
    asc_link_e          link;
    logic               ck_prev;
    logic               cs_prev;
    logic [CNT_W-1:0]   rise_cnt;
    logic [CNT_W-1:0]   fall_cnt;
    logic [CNT_W-1:0]   len;
    logic [DIN_W-1:0]   in_sr;
    logic [ADDR_W-1:0]  mux_sel;
    logic [RES_W-1:0]   out_sr;
    logic               dout;
    logic               oe;
    logic               sampling;
    logic [RES_W-1:0]   held;
    logic [RES_W-1:0]   result;
    logic               conv_busy;
    logic [CONV_W-1:0]  conv_cnt;
    logic               eoc;
  } asc_state_s;

  localparam asc_state_s ASC_STATE_RST = '{
    link:      LK_IDLE,
    ck_prev:   1'b0,
    cs_prev:   1'b1,
    rise_cnt:  5'h00,
    fall_cnt:  5'h00,
    len:       LEN_12,
    in_sr:     8'h00,
    mux_sel:   4'h0,
    out_sr:    12'h000,
    dout:      1'b0,
    oe:        1'b0,
    sampling:  1'b0,
    held:      12'h000,
    result:    12'h000,
    conv_busy: 1'b0,
    conv_cnt:  9'h000,
    eoc:       1'b1
  };

endpackage

// ---- rtl/asc_sync.sv ----
`timescale 1ns/1ps
module asc_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Two stages; only the second stage is visible outside
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= RST;
      q        <= RST;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ---- rtl/asc_port.sv ----
`timescale 1ns/1ps
module asc_port
  import asc_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          rstn,
  input  wire logic                          cs_n,
  input  wire logic                          io_clk,
  input  wire logic                          data_in,
  output logic                               data_out,
  output logic                               data_out_oe,
  output logic                               eoc,
  input  wire logic                          msb_first,
  input  wire logic                          bipolar,
  input  wire logic [1:0]                    len_sel,
  input  wire logic [asc_pkg::N_EXT-1:0][asc_pkg::RES_W-1:0] analog_inputs,
  output logic      [asc_pkg::ADDR_W-1:0]    mux_sel,
  output logic                               sampling,
  output logic      [asc_pkg::DIN_W-1:0]     input_reg
);
  import asc_pkg::*;

  asc_state_s        state_reg;
  asc_state_s        state_next;
  logic [2:0]        pins_s;
  logic              cs_s;
  logic              ck_s;
  logic              di_s;
  logic              ck_rise;
  logic              ck_fall;
  logic              cs_fall;
  logic              cs_rise;
  logic              last_fall;
  logic [CNT_W-1:0]  fall_inc;
  logic [CNT_W-1:0]  len_now;
  logic [RES_W-1:0]  mux_code;
  logic [RES_W-1:0]  conv_fmt;
  logic [RES_W-1:0]  first_word;

  // Pins come from the host's domain, so all three pass two flops
  asc_sync #(
    .W   (3),
    .RST (SYNC_RST)
  ) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     ({data_in, io_clk, cs_n}),
    .q     (pins_s)
  );

  assign cs_s = pins_s[0];
  assign ck_s = pins_s[1];
  assign di_s = pins_s[2];

  // Edge finders on the synchronised levels
  assign ck_rise   = ck_s & ~state_reg.ck_prev;
  assign ck_fall   = ~ck_s & state_reg.ck_prev;
  assign cs_fall   = ~cs_s & state_reg.cs_prev;
  assign cs_rise   = cs_s & ~state_reg.cs_prev;
  assign fall_inc  = state_reg.fall_cnt + 5'h01;
  assign last_fall = (state_reg.link == LK_SHIFT) && !cs_rise && ck_fall
                     && (fall_inc == state_reg.len);

  // Transfer length from the select code, taken at each start
  always_comb begin
    unique case (len_sel)
      LEN_SEL_8:  len_now = LEN_8;
      LEN_SEL_16: len_now = LEN_16;
      default:    len_now = LEN_12;
    endcase
  end

  // Input multiplexer; addresses past the self-tests select nothing
  always_comb begin
    mux_code = CODE_NONE;
    if (state_reg.mux_sel < ADDR_W'(N_EXT)) begin
      mux_code = analog_inputs[state_reg.mux_sel];
    end else if (state_reg.mux_sel == SEL_TEST_MID) begin
      mux_code = TEST_MID;
    end else if (state_reg.mux_sel == SEL_TEST_LO) begin
      mux_code = TEST_LO;
    end else if (state_reg.mux_sel == SEL_TEST_HI) begin
      mux_code = TEST_HI;
    end
  end

  // Bipolar flips the top bit: offset binary about mid-scale to signed
  assign conv_fmt = bipolar ? {~state_reg.held[RES_W-1], state_reg.held[RES_W-2:0]}
                            : state_reg.held;

  // Lsb-first order is a bit-reversed load, so shifting stays one way
  always_comb begin
    first_word = state_reg.result;
    if (!msb_first) begin
      for (int i = 0; i < RES_W; i++) begin
        first_word[i] = state_reg.result[RES_W-1-i];
      end
    end
  end

  // Next state of the link and the converter
  always_comb begin
    state_next         = state_reg;
    state_next.ck_prev = ck_s;
    state_next.cs_prev = cs_s;
    state_next.oe      = ~cs_s;

    // Track the selected input while sampling; last value is held
    if (state_reg.sampling) begin
      state_next.held = mux_code;
    end

    // Conversion runs on the local clock once handed over
    if (state_reg.conv_busy) begin
      if (state_reg.conv_cnt == CONV_LAST) begin
        state_next.conv_busy = 1'b0;
        state_next.conv_cnt  = '0;
        state_next.result    = conv_fmt;
        state_next.eoc       = 1'b1;
      end else begin
        state_next.conv_cnt = state_reg.conv_cnt + 9'h001;
      end
    end

    unique case (state_reg.link)
      LK_IDLE: begin
        if (cs_fall) begin
          state_next.link     = LK_SHIFT;
          state_next.rise_cnt = '0;
          state_next.fall_cnt = '0;
          state_next.in_sr    = '0;
          state_next.len      = len_now;
          state_next.out_sr   = first_word;
          state_next.dout     = first_word[RES_W-1];
        end
      end
      LK_SHIFT: begin
        if (cs_rise) begin
          // Early end: no conversion, sampling dropped
          state_next.link     = LK_IDLE;
          state_next.sampling = 1'b0;
        end else begin
          if (ck_rise && (state_reg.rise_cnt < DIN_RISES)) begin
            state_next.in_sr    = {state_reg.in_sr[DIN_W-2:0], di_s};
            state_next.rise_cnt = state_reg.rise_cnt + 5'h01;
            if (state_reg.rise_cnt == ADDR_RISES - 5'h01) begin
              state_next.mux_sel = {state_reg.in_sr[ADDR_W-2:0], di_s};
            end
          end
          if (ck_fall) begin
            state_next.fall_cnt = fall_inc;
            state_next.out_sr   = {state_reg.out_sr[RES_W-2:0], 1'b0};
            state_next.dout     = state_reg.out_sr[RES_W-2];
            if (fall_inc == SAMPLE_FALL) begin
              state_next.sampling = 1'b1;
            end
            if (last_fall) begin
              state_next.sampling  = 1'b0;
              state_next.conv_busy = 1'b1;
              state_next.conv_cnt  = '0;
              state_next.eoc       = 1'b0;
              state_next.link      = LK_DONE;
            end
          end
        end
      end
      LK_DONE: begin
        // Extra clocks are ignored until select goes high
        if (cs_rise) begin
          state_next.link = LK_IDLE;
        end
      end
      default: begin
        state_next.link = LK_IDLE;
      end
    endcase
  end

  // All state in one register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ASC_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign data_out    = state_reg.dout;
  assign data_out_oe = state_reg.oe;
  assign eoc         = state_reg.eoc;
  assign mux_sel     = state_reg.mux_sel;
  assign sampling    = state_reg.sampling;
  assign input_reg   = state_reg.in_sr;

  a_oe_off_high: assert property (
    @(posedge clock) disable iff (!rstn)
    cs_s |=> !data_out_oe)
    else $error("serial output driven while select high");

  a_oe_on_low: assert property (
    @(posedge clock) disable iff (!rstn)
    !cs_s |=> data_out_oe)
    else $error("serial output floating while select low");

  a_start_clear: assert property (
    @(posedge clock) disable iff (!rstn)
    (cs_fall && state_reg.link == LK_IDLE) |=>
      (state_reg.rise_cnt == '0) && (state_reg.fall_cnt == '0)
      && (state_reg.link == LK_SHIFT))
    else $error("counters not cleared at select fall");

  a_first_msb: assert property (
    @(posedge clock) disable iff (!rstn)
    (cs_fall && state_reg.link == LK_IDLE && msb_first) |=>
      data_out == $past(state_reg.result[RES_W-1]))
    else $error("first bit is not the result msb");

  a_first_lsb: assert property (
    @(posedge clock) disable iff (!rstn)
    (cs_fall && state_reg.link == LK_IDLE && !msb_first) |=>
      data_out == $past(state_reg.result[0]))
    else $error("first bit is not the result lsb");

  a_dout_on_fall: assert property (
    @(posedge clock) disable iff (!rstn)
    $changed(data_out) |-> $past(ck_fall || cs_fall))
    else $error("serial output changed away from a falling edge");

  a_idle_frozen: assert property (
    @(posedge clock) disable iff (!rstn)
    (cs_s && state_reg.link != LK_SHIFT) |=>
      $stable(state_reg.rise_cnt) && $stable(state_reg.in_sr))
    else $error("input taken while select high");

  a_addr_capture: assert property (
    @(posedge clock) disable iff (!rstn)
    (state_reg.link == LK_SHIFT && !cs_rise && ck_rise
      && state_reg.rise_cnt == 5'h03) |=>
      mux_sel == $past({state_reg.in_sr[2:0], di_s}))
    else $error("channel address not taken on fourth rise");

  a_sample_start: assert property (
    @(posedge clock) disable iff (!rstn)
    (state_reg.link == LK_SHIFT && !cs_rise && ck_fall
      && state_reg.fall_cnt == 5'h03 && !last_fall) |=> sampling)
    else $error("sampling did not start on fourth fall");

  a_handover: assert property (
    @(posedge clock) disable iff (!rstn)
    last_fall |=> !eoc && state_reg.conv_busy && !sampling)
    else $error("last fall did not start a conversion");

  a_eoc_holds: assert property (
    @(posedge clock) disable iff (!rstn)
    $fell(eoc) |-> !eoc [*8])
    else $error("end of conversion rose too early");

  a_conv_time: assert property (
    @(posedge clock) disable iff (!rstn)
    $fell(eoc) |-> ##[1:500] eoc)
    else $error("conversion took longer than ten microseconds");

  a_bipolar_fmt: assert property (
    @(posedge clock) disable iff (!rstn)
    (state_reg.conv_busy && state_reg.conv_cnt == CONV_LAST && bipolar) |=>
      state_reg.result[RES_W-1] == !$past(state_reg.held[RES_W-1]))
    else $error("bipolar result sign bit wrong");

  a_abort_idle: assert property (
    @(posedge clock) disable iff (!rstn)
    (state_reg.link == LK_SHIFT && cs_rise) |=>
      (state_reg.link == LK_IDLE) && !sampling)
    else $error("early select rise did not end the transfer");

  a_test_high: assert property (
    @(posedge clock) disable iff (!rstn)
    (state_reg.sampling && state_reg.mux_sel == SEL_TEST_HI) |=>
      state_reg.held == TEST_HI)
    else $error("high self-test voltage not selected");

  a_eoc_on_done: assert property (
    @(posedge clock) disable iff (!rstn)
    $rose(eoc) |-> $past(state_reg.conv_busy))
    else $error("end of conversion rose with no conversion running");

  a_len_bound: assert property (
    @(posedge clock) disable iff (!rstn)
    (state_reg.link == LK_SHIFT) |-> (state_reg.fall_cnt < state_reg.len))
    else $error("transfer ran past its programmed length");

endmodule

// ---- sim/asc_host.sv ----
`timescale 1ns/1ps
module asc_host (
  input  wire logic clock,
  input  wire logic dout_pin,
  output logic      cs_n,
  output logic      io_clk,
  output logic      data_in
);
  // Idle frame state: select high, serial clock parked low
  initial begin
    cs_n    = 1'h1;
    io_clk  = 1'h0;
    data_in = 1'h0;
  end

  // Host frame; stop below nclk raises select early to abort
  task automatic xfer(input logic [7:0] din, input int nclk, input int stop,
                      output logic [15:0] rx);
    int i;
    rx = '0;
    @(posedge clock);
    cs_n    <= 1'h0;
    data_in <= din[7];
    for (i = 0; i < nclk && i < stop; i++) begin
      // Four clocks low, four high: a 160 ns serial clock
      repeat (3) @(posedge clock);
      io_clk <= 1'h1;
      repeat (4) @(posedge clock);
      rx     = {rx[14:0], dout_pin}; // Late in the high phase, far from any output change
      io_clk <= 1'h0;
      @(posedge clock);
      data_in <= (i < 7) ? din[6-i] : ~data_in;
    end
    repeat (4) @(posedge clock);
    cs_n    <= 1'h1;
    data_in <= ~data_in; // Released line shows no stale bit
    @(posedge clock);
  endtask
endmodule

// ---- sim/asc_port_tb.sv ----
`timescale 1ns/1ps
module asc_port_tb;
  import asc_pkg::*;
  typedef struct packed {
    logic [7:0] din;
    logic       msb;
    logic       bip;
    logic [1:0] len;
  } asc_row_s;

  logic                        clock;
  logic                        rstn;
  logic                        cs_n;
  logic                        io_clk;
  logic                        data_in;
  logic                        data_out;
  logic                        data_out_oe;
  logic                        eoc;
  logic                        msb_first;
  logic                        bipolar;
  logic                        sampling;
  logic [1:0]                  len_sel;
  logic [N_EXT-1:0][RES_W-1:0] analog_inputs;
  logic [ADDR_W-1:0]           mux_sel;
  logic [DIN_W-1:0]            input_reg;
  logic [RES_W-1:0]            prev;
  logic [15:0]                 rx;
  wire                         dout_pin;
  int                          error_cnt;
  int                          checked;
  int                          cyc;
  int                          samp_cnt;
  // Address nibble, mode nibble, bit order, coding, length select
  asc_row_s rows [8] = '{'{8'h35, 1'h1, 1'h0, 2'h0}, '{8'hA2, 1'h0, 1'h0, 2'h1},
                         '{8'hBF, 1'h1, 1'h1, 2'h3}, '{8'hC0, 1'h0, 1'h1, 2'h2},
                         '{8'hD9, 1'h1, 1'h0, 2'h3}, '{8'hE4, 1'h1, 1'h0, 2'h0},
                         '{8'hF1, 1'h0, 1'h1, 2'h1}, '{8'h06, 1'h1, 1'h1, 2'h0}};

  // Three-state pin as the host sees it
  assign dout_pin = data_out_oe ? data_out : 1'hz;

  asc_port u_dut (.clock(clock), .rstn(rstn), .cs_n(cs_n), .io_clk(io_clk),
    .data_in(data_in), .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc),
    .msb_first(msb_first), .bipolar(bipolar), .len_sel(len_sel),
    .analog_inputs(analog_inputs), .mux_sel(mux_sel), .sampling(sampling),
    .input_reg(input_reg));

  asc_host u_host (.clock(clock), .dout_pin(dout_pin), .cs_n(cs_n), .io_clk(io_clk),
    .data_in(data_in));

  // Clock, plus cycle ceiling so a stuck end of conversion cannot hang the run
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (sampling === 1'h1) samp_cnt++;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Code the converter should deliver for a selection
  function automatic logic [RES_W-1:0] exp_code(logic [3:0] a, logic b);
    logic [RES_W-1:0] c;
    c = (a < 4'hB) ? analog_inputs[a] : (a == SEL_TEST_MID) ? TEST_MID :
        (a == SEL_TEST_LO) ? TEST_LO : (a == SEL_TEST_HI) ? TEST_HI : CODE_NONE;
    return b ? {~c[11], c[10:0]} : c;
  endfunction

  // Bits the host should collect, zero padded past twelve
  function automatic logic [15:0] exp_ser(logic [RES_W-1:0] r, logic m, int n);
    logic [15:0] s;
    s = '0;
    for (int i = 0; i < n; i++) s = {s[14:0], (i < 12) ? (m ? r[11-i] : r[i]) : 1'h0};
    return s;
  endfunction

  function automatic int len_clk(logic [1:0] l);
    return (l == LEN_SEL_8) ? 8 : (l == LEN_SEL_16) ? 16 : 12;
  endfunction

  // Full transfer, then the wait for the conversion it started
  task automatic run_row(input asc_row_s r, input logic [RES_W-1:0] exp_rd);
    int n;
    int w;
    int s0;
    n = len_clk(r.len);
    @(posedge clock);
    msb_first <= r.msb;
    bipolar   <= r.bip;
    len_sel   <= r.len;
    s0 = samp_cnt;
    u_host.xfer(r.din, n, n, rx);
    chk_val("serial result", exp_ser(exp_rd, r.msb, n), rx);
    chk_val("mux_sel", 16'(r.din[7:4]), 16'(mux_sel));
    chk_val("input_reg", 16'(r.din), 16'(input_reg));
    chk_val("eoc after last clock", 16'h0000, 16'(eoc));
    w = samp_cnt - s0;
    chk_cnt("sampling window", 1, int'(w >= (n-4)*8-2 && w <= (n-4)*8+2));
    w = 0;
    while (eoc !== 1'h1 && w < 600) begin
      @(negedge clock);
      w++;
    end
    chk_cnt("conversion time", 1, int'(w >= CONV_CYC-10 && w <= CONV_CYC));
    chk_val("oe idle", 16'h0000, 16'(data_out_oe));
  endtask

  initial begin
    rstn      = 1'h0;
    msb_first = 1'h1;
    bipolar   = 1'h0;
    len_sel   = 2'h0;
    error_cnt = 0;
    checked   = 0;
    cyc       = 0;
    samp_cnt  = 0;
    for (int i = 0; i < N_EXT; i++) analog_inputs[i] = 12'h0A5 + 12'(i) * 12'h171;
    repeat (16) @(posedge clock);
    rstn <= 1'h1;
    repeat (3) @(posedge clock);
    prev = 12'h000;
    foreach (rows[i]) begin
      run_row(rows[i], prev);
      prev = exp_code(rows[i].din[7:4], rows[i].bip);
      $display("Row %0d done", i);
    end
    // Select raised after five clocks: no conversion, old result kept
    u_host.xfer(8'h29, 12, 5, rx);
    repeat (20) @(negedge clock);
    chk_val("eoc after abort", 16'h0001, 16'(eoc));
    run_row(rows[0], prev);
    prev = exp_code(rows[0].din[7:4], rows[0].bip);
    $display("Abort test done");
    // Reset while a conversion is running
    u_host.xfer(rows[1].din, 12, 12, rx);
    @(posedge clock);
    rstn <= 1'h0;
    repeat (2) @(negedge clock);
    chk_val("reset outputs", 16'h4000, 16'({eoc, data_out_oe, sampling, mux_sel, input_reg}));
    @(posedge clock);
    rstn <= 1'h1;
    repeat (3) @(posedge clock);
    run_row(rows[3], 12'h000);
    $display("Reset test done");
    give_verdict();
  end
endmodule
